// *** mswd_params.svh ***
// constants and timing counts for the switch status serial framing block
// Function
// - select low: take command, shift status out
// - select fall: enable output, capture interrupt, switches
// - select rise: output driver off, high impedance
// - select rise: release interrupt unless new change
// - command word applied only at select rise
// - select reads high when undriven
// - select fall wakes device from sleep
// - wetting pulse lasts 15 to 20 ms
// - interrupt asserted within 16 us of change; the code arms it in normal mode only, never while asleep
// - sleep scan samples inputs 100 to 300 us
// - sleep timers within ten percent of period
// - transfer is exactly 24 serial bits
// - input bit sampled on clock falling edge
// - status bit 24 out on first rising edge
// - both words shifted most significant bit first
`ifndef MSWD_PARAMS_SVH
`define MSWD_PARAMS_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define MSWD_CLK_MHZ 125
`define MSWD_FRAME_BITS 24
`define MSWD_SWITCHES 22
`define MSWD_WET_US 16000
`define MSWD_WET_CYC (`MSWD_WET_US * `MSWD_CLK_MHZ)
`define MSWD_INT_DLY_NS 5000
`define MSWD_INT_DLY_CYC ((`MSWD_INT_DLY_NS * `MSWD_CLK_MHZ) / 1000)
`define MSWD_SCAN_US 200
`define MSWD_SCAN_CYC (`MSWD_SCAN_US * `MSWD_CLK_MHZ)
`define MSWD_SCAN_PERIOD_US 64000
`define MSWD_SCAN_PERIOD_CYC (`MSWD_SCAN_PERIOD_US * `MSWD_CLK_MHZ)
`endif

// *** mswd_pkg.sv ***
// types shared by the switch status serial framing block
`default_nettype none
package mswd_pkg;
   typedef enum logic [1:0] {mswd_normal, mswd_sleep_idle, mswd_sleep_scan} mswd_mode_e;
endpackage
`default_nettype wire

// *** mswd_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module mswd_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous input and synchronised output
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // first stage feeds only the second
   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule // mswd_sync
`default_nettype wire

// *** mswd_timer.sv ***
// down counter that times a one-shot interval
`timescale 1ns/1ns
`default_nettype none
module mswd_timer #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic start,
   input wire logic [WIDTH-1:0] load,
   // status
   output logic busy,
   output logic done
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic next_done;

   // reload on start, count down to zero, pulse done at the end
   always_comb begin
      next_count = count;
      next_done = 1'b0;
      if (start) begin
         next_count = load;
      end else if (count != '0) begin
         next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
         next_done = (count == {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= '0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         done <= next_done;
      end
   end

   assign busy = (count != '0);
endmodule // mswd_timer
`default_nettype wire

// *** mswd_core.sv ***
// serial framing, status capture, interrupt and sleep timing of the switch interface
`timescale 1ns/1ns
`default_nettype none
`include "mswd_params.svh"
module mswd_core #(
   parameter int NSW = `MSWD_SWITCHES,
   parameter int WET_CYC = `MSWD_WET_CYC,
   parameter int INT_DLY_CYC = `MSWD_INT_DLY_CYC,
   parameter int SCAN_CYC = `MSWD_SCAN_CYC,
   parameter int SCAN_PERIOD_CYC = `MSWD_SCAN_PERIOD_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial link pins
   input wire logic cs_n_pin,
   input wire logic cs_n_driven,
   input wire logic sclk,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   // interrupt open-drain pin
   output logic int_n_o,
   output logic int_n_oe,
   // switch inputs, closed reads as one
   input wire logic [NSW-1:0] sw_in,
   // mode control and flags
   input wire logic sleep_req,
   input wire logic thermal_flag,
   output logic asleep,
   output logic wake_event,
   output logic scan_active,
   output logic wet_active,
   // applied command word
   output logic [`MSWD_FRAME_BITS-1:0] cmd_word,
   output logic cmd_valid
);
   localparam int FB = `MSWD_FRAME_BITS;

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   logic cs_raw;
   logic cs_s;
   logic sclk_s;
   logic si_s;
   logic [NSW-1:0] sw_s;

   // undriven select floats high through the pull-up
   assign cs_raw = cs_n_driven ? cs_n_pin : 1'b1;

   mswd_sync #(.WIDTH(1), .INIT(1'b1)) u_cs (.clk(clk), .rst(rst), .d(cs_raw), .q(cs_s));
   mswd_sync #(.WIDTH(1), .INIT(1'b0)) u_sclk (.clk(clk), .rst(rst), .d(sclk), .q(sclk_s));
   mswd_sync #(.WIDTH(1), .INIT(1'b0)) u_si (.clk(clk), .rst(rst), .d(si), .q(si_s));
   mswd_sync #(.WIDTH(NSW), .INIT('0)) u_sw (.clk(clk), .rst(rst), .d(sw_in), .q(sw_s));

   // ----------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------
   logic cs_d;
   logic sclk_d;
   logic [NSW-1:0] sw_d;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic sw_change;

   always_ff @(posedge clk) begin
      if (rst) begin
         cs_d <= 1'b1;
         sclk_d <= 1'b0;
         sw_d <= '0;
      end else begin
         cs_d <= cs_s;
         sclk_d <= sclk_s;
         sw_d <= sw_s;
      end
   end

   assign cs_fall = cs_d & ~cs_s;
   assign cs_rise = ~cs_d & cs_s;
   // clock edges count only inside a frame
   assign sclk_rise = ~cs_s & ~sclk_d & sclk_s;
   assign sclk_fall = ~cs_s & sclk_d & ~sclk_s;
   assign sw_change = (sw_s != sw_d);

   // ----------------------------------------------------------------
   // shift registers and frame counter
   // ----------------------------------------------------------------
   logic [FB-1:0] rx_sh;
   logic [FB-1:0] tx_sh;
   logic [5:0] bit_cnt;
   logic so_bit;
   logic so_en;
   logic [FB-1:0] next_rx_sh;
   logic [FB-1:0] next_tx_sh;
   logic [5:0] next_bit_cnt;
   logic next_so_bit;
   logic next_so_en;
   logic int_pend;

   // status word: interrupt flag, thermal flag, switch states
   function automatic logic [FB-1:0] status_word(input logic intf, input logic therm,
                                                 input logic [NSW-1:0] sw);
      logic [FB-1:0] w;
      w = '0;
      w[FB-1] = intf;
      w[FB-2] = therm;
      w[NSW-1:0] = sw;
      return w;
   endfunction

   always_comb begin
      next_rx_sh = rx_sh;
      next_tx_sh = tx_sh;
      next_bit_cnt = bit_cnt;
      next_so_bit = so_bit;
      next_so_en = so_en;
      if (cs_fall) begin
         // capture interrupt and switch states, drive output
         next_so_en = 1'b1;
         next_tx_sh = status_word(int_pend, thermal_flag, sw_s);
         next_bit_cnt = '0;
      end else if (cs_rise) begin
         next_so_en = 1'b0;
      end else if (~cs_s) begin
         if (sclk_rise) begin
            // msb leaves first, bit 24 on the first rising edge
            next_so_bit = tx_sh[FB-1];
            next_tx_sh = {tx_sh[FB-2:0], 1'b0};
         end
         if (sclk_fall) begin
            next_rx_sh = {rx_sh[FB-2:0], si_s};
            if (bit_cnt != 6'h3f) begin
               next_bit_cnt = bit_cnt + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_sh <= '0;
         tx_sh <= '0;
         bit_cnt <= '0;
         so_bit <= 1'b0;
         so_en <= 1'b0;
      end else begin
         rx_sh <= next_rx_sh;
         tx_sh <= next_tx_sh;
         bit_cnt <= next_bit_cnt;
         so_bit <= next_so_bit;
         so_en <= next_so_en;
      end
   end

   assign so_o = so_bit;
   assign so_oe = so_en;

   // ----------------------------------------------------------------
   // command activation
   // ----------------------------------------------------------------
   logic [FB-1:0] next_cmd_word;
   logic next_cmd_valid;

   // only a full 24-bit frame is applied, and only at select rise
   always_comb begin
      next_cmd_word = cmd_word;
      next_cmd_valid = 1'b0;
      if (cs_rise && bit_cnt == 6'(FB)) begin
         next_cmd_word = rx_sh;
         next_cmd_valid = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_word <= '0;
         cmd_valid <= 1'b0;
      end else begin
         cmd_word <= next_cmd_word;
         cmd_valid <= next_cmd_valid;
      end
   end

   // ----------------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------------
   logic int_arm;
   logic chg_in_frame;
   logic int_dly_done;
   logic int_dly_busy;
   logic next_int_pend;
   logic next_chg_in_frame;

   assign int_arm = sw_change & ~int_pend & ~int_dly_busy & (asleep == 1'b0);

   // delay from switch change to interrupt, well inside the bound
   mswd_timer #(.WIDTH(32)) u_int_dly (
      .clk(clk), .rst(rst), .start(int_arm), .load(32'(INT_DLY_CYC)),
      .busy(int_dly_busy), .done(int_dly_done));

   // change during a frame keeps the interrupt; set wins over clear
   always_comb begin
      next_int_pend = int_pend;
      next_chg_in_frame = chg_in_frame;
      if (cs_fall) begin
         next_chg_in_frame = 1'b0;
      end else if (~cs_s && sw_change) begin
         next_chg_in_frame = 1'b1;
      end
      if (cs_rise && !chg_in_frame && !sw_change) begin
         next_int_pend = 1'b0;
      end
      if (int_dly_done) begin
         next_int_pend = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         int_pend <= 1'b0;
         chg_in_frame <= 1'b0;
      end else begin
         int_pend <= next_int_pend;
         chg_in_frame <= next_chg_in_frame;
      end
   end

   assign int_n_o = 1'b0;
   assign int_n_oe = int_pend;

   // ----------------------------------------------------------------
   // mode, sleep scan and wetting pulse
   // ----------------------------------------------------------------
   mswd_pkg::mswd_mode_e mode;
   mswd_pkg::mswd_mode_e next_mode;
   logic scan_done;
   logic scan_busy;
   logic period_done;
   logic scan_start;
   logic period_start;
   logic next_wake_event;
   logic wet_start;

   // scan window and scan period, both derived from the one clock
   mswd_timer #(.WIDTH(32)) u_scan (
      .clk(clk), .rst(rst), .start(scan_start), .load(32'(SCAN_CYC)),
      .busy(scan_busy), .done(scan_done));
   mswd_timer #(.WIDTH(32)) u_period (
      .clk(clk), .rst(rst), .start(period_start), .load(32'(SCAN_PERIOD_CYC)),
      .busy(), .done(period_done));

   always_comb begin
      next_mode = mode;
      scan_start = 1'b0;
      period_start = 1'b0;
      next_wake_event = 1'b0;
      unique case (mode)
         mswd_pkg::mswd_normal: begin
            if (sleep_req && cs_s && !int_pend) begin
               next_mode = mswd_pkg::mswd_sleep_idle;
               period_start = 1'b1;
            end
         end
         mswd_pkg::mswd_sleep_idle: begin
            if (cs_fall) begin
               next_mode = mswd_pkg::mswd_normal;
               next_wake_event = 1'b1;
            end else if (period_done) begin
               next_mode = mswd_pkg::mswd_sleep_scan;
               scan_start = 1'b1;
            end
         end
         mswd_pkg::mswd_sleep_scan: begin
            if (cs_fall) begin
               next_mode = mswd_pkg::mswd_normal;
               next_wake_event = 1'b1;
            end else if (scan_done) begin
               if (sw_change) begin
                  next_mode = mswd_pkg::mswd_normal;
                  next_wake_event = 1'b1;
               end else begin
                  next_mode = mswd_pkg::mswd_sleep_idle;
                  period_start = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode <= mswd_pkg::mswd_normal;
         wake_event <= 1'b0;
      end else begin
         mode <= next_mode;
         wake_event <= next_wake_event;
      end
   end

   assign asleep = (mode != mswd_pkg::mswd_normal);
   assign scan_active = (mode == mswd_pkg::mswd_sleep_scan) & scan_busy;

   // wetting pulse starts on each switch change in normal mode
   assign wet_start = sw_change & ~asleep;
   mswd_timer #(.WIDTH(32)) u_wet (
      .clk(clk), .rst(rst), .start(wet_start), .load(32'(WET_CYC)),
      .busy(wet_active), .done());

endmodule // mswd_core
`default_nettype wire

// *** mswd_core_properties.sv ***
// assertions on the switch status serial framing ports
`timescale 1ns/1ns
`default_nettype none
`include "mswd_params.svh"
module mswd_checker #(
   parameter int NSW = 22,
   parameter int WET_CYC = 50,
   parameter int INT_DLY_CYC = 10,
   parameter int SCAN_CYC = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic cs_n_pin,
   input wire logic cs_n_driven,
   input wire logic so_oe,
   // interrupt pin and switches
   input wire logic int_n_o,
   input wire logic int_n_oe,
   input wire logic [NSW-1:0] sw_in,
   // flags and command
   input wire logic asleep,
   input wire logic wake_event,
   input wire logic scan_active,
   input wire logic wet_active,
   input wire logic [`MSWD_FRAME_BITS-1:0] cmd_word,
   input wire logic cmd_valid
);
   localparam int INT_MAX = INT_DLY_CYC + 6;
   logic cs_hi;
   logic [31:0] scan_run;
   logic [31:0] wet_run;
   // select level as the pull-up leaves it
   assign cs_hi = cs_n_pin | ~cs_n_driven;
   // run lengths of scan and wetting windows
   always_ff @(posedge clk) begin
      scan_run <= (rst || !scan_active) ? 32'h0 : scan_run + 32'h1;
      wet_run <= (rst || !wet_active) ? 32'h0 : wet_run + 32'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   so_enable_a: assert property ($fell(cs_hi) |-> ##[2:4] so_oe)
      else $error("output not enabled after select fall");
   so_release_a: assert property ($rose(cs_hi) |-> ##[2:4] !so_oe)
      else $error("output not released after select rise");
   so_idle_a: assert property (cs_hi [*6] |-> !so_oe)
      else $error("output driven while deselected");
   cmd_apply_a: assert property (!$stable(cmd_word) |-> cmd_valid && $past(cs_hi, 3))
      else $error("command word changed outside select rise");
   irq_raise_a: assert property ($changed(sw_in) && cs_hi && !asleep && !int_n_oe
      |-> ##[1:INT_MAX] int_n_oe)
      else $error("interrupt late after switch change");
   irq_clear_a: assert property ($fell(int_n_oe) |-> cs_hi && $past(cs_hi))
      else $error("interrupt released while selected");
   irq_drive_a: assert property (int_n_oe |-> !int_n_o)
      else $error("interrupt pin not pulled low");
   wake_up_a: assert property (asleep && $fell(cs_hi) |-> ##[1:5] (wake_event && !asleep))
      else $error("select fall did not wake");
   scan_time_a: assert property ($fell(scan_active) && !$past(rst)
      |-> scan_run >= SCAN_CYC / 2 && scan_run <= SCAN_CYC * 3 / 2)
      else $error("scan window length wrong");
   wet_time_a: assert property ($fell(wet_active) && !$past(rst)
      |-> wet_run >= WET_CYC * 15 / 16 && wet_run <= WET_CYC * 20 / 16 + 1)
      else $error("wetting pulse length wrong");
   // main scenarios
   cover property ($rose(cmd_valid));
   cover property (wake_event);
   cover property ($fell(scan_active));
   cover property ($fell(int_n_oe));
endmodule // mswd_checker
bind mswd_core mswd_checker #(.NSW(NSW), .WET_CYC(WET_CYC), .INT_DLY_CYC(INT_DLY_CYC),
   .SCAN_CYC(SCAN_CYC)) mswd_checker_i (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin),
   .cs_n_driven(cs_n_driven), .so_oe(so_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
   .sw_in(sw_in), .asleep(asleep), .wake_event(wake_event), .scan_active(scan_active),
   .wet_active(wet_active), .cmd_word(cmd_word), .cmd_valid(cmd_valid));
`default_nettype wire

// *** mswd_master.sv ***
// model of the serial bus master facing the switch interface
`timescale 1ns/1ns
`default_nettype none
module mswd_master (
   // clock
   input wire logic clk,
   // select, serial clock and data out
   output logic cs_n_pin,
   output logic cs_n_driven,
   output logic sclk,
   output logic si,
   // data back from the device
   input wire logic so_o,
   input wire logic so_oe
);
   // idle: deselected, serial clock parked low
   initial begin
      cs_n_pin = 1'b1;
      cs_n_driven = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // one frame of k bits, msb first, 80 ns serial clock
   task automatic xfer(input logic [23:0] cmd, input int k, output logic [23:0] st);
      st = 24'h0;
      @(posedge clk);
      cs_n_pin <= 1'b0;
      repeat (8) @(posedge clk);
      for (int i = 0; i < k; i++) begin
         si <= cmd[23-i];
         sclk <= 1'b1;
         repeat (5) @(posedge clk);
         st = {st[22:0], so_oe ? so_o : 1'bx};
         sclk <= 1'b0;
         repeat (5) @(posedge clk);
      end
      cs_n_pin <= 1'b1;
      si <= ~si; // released data line moves away
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask
   // leave select undriven and low, report output enable
   task automatic float_sel(input int k, output logic oe);
      @(posedge clk);
      cs_n_driven <= 1'b0;
      cs_n_pin <= 1'b0;
      repeat (k) @(posedge clk);
      oe = so_oe;
      cs_n_driven <= 1'b1;
      cs_n_pin <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask
endmodule // mswd_master
`default_nettype wire

// *** mswd_core_bench.sv ***
// self-checking bench of the switch status serial framing block
`timescale 1ns/1ns
`default_nettype none
module mswd_core_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire logic cs_n_pin, cs_n_driven, sclk, si;
   logic so_o, so_oe, int_n_o, int_n_oe, asleep, wake_event, scan_active, wet_active;
   logic cmd_valid, oe;
   logic sleep_req = 1'b0;
   logic thermal_flag = 1'b0;
   logic [21:0] sw_in = 22'h0;
   logic [23:0] cmd_word, st;
   int bad_count = 0;
   int checks_done = 0;
   int n;
   // 125 MHz clock
   initial forever #4 clk = ~clk;
   mswd_core #(.WET_CYC(50), .INT_DLY_CYC(10), .SCAN_CYC(20), .SCAN_PERIOD_CYC(100))
      mswd_core_i (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .cs_n_driven(cs_n_driven),
      .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe), .int_n_o(int_n_o),
      .int_n_oe(int_n_oe), .sw_in(sw_in), .sleep_req(sleep_req),
      .thermal_flag(thermal_flag), .asleep(asleep), .wake_event(wake_event),
      .scan_active(scan_active), .wet_active(wet_active), .cmd_word(cmd_word),
      .cmd_valid(cmd_valid));
   mswd_master mswd_master_i (.clk(clk), .cs_n_pin(cs_n_pin), .cs_n_driven(cs_n_driven),
      .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe));
   // compare and count
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   // level picked by number: 0 interrupt, 1 asleep, else scan window
   function automatic logic lvl(input int which);
      case (which)
         0: return int_n_oe;
         1: return asleep;
         default: return scan_active;
      endcase
   endfunction
   // bounded wait for a level, n counts cycles
   task automatic wait_lvl(input int which, input logic v);
      n = 0;
      while (lvl(which) !== v && n < 400) begin
         @(negedge clk);
         n++;
      end
   endtask
   // switch change, two frames back to back
   task automatic t_frame();
      @(posedge clk);
      sw_in <= 22'h2a5c3f;
      thermal_flag <= 1'b1;
      wait_lvl(0, 1'b1);
      chk("irq raise", 1'b1, int_n_oe);
      mswd_master_i.xfer(24'ha5c3e1, 24, st);
      chk("status", {2'b11, 22'h2a5c3f}, st);
      chk("cmd word", 24'ha5c3e1, cmd_word);
      chk("irq clear", 1'b0, int_n_oe);
      chk("so off", 1'b0, so_oe);
      mswd_master_i.xfer(24'h3c5a96, 24, st);
      chk("status 2", {2'b01, 22'h2a5c3f}, st);
      chk("cmd word 2", 24'h3c5a96, cmd_word);
      $display("frame test done");
   endtask
   // frame one bit short is thrown away
   task automatic t_short();
      mswd_master_i.xfer(24'h0f0f0f, 23, st);
      chk("short frame", 24'h3c5a96, cmd_word);
      $display("short frame test done");
   endtask
   // switch change while selected keeps the interrupt
   task automatic t_keep();
      fork
         mswd_master_i.xfer(24'h123456, 24, st);
         begin
            repeat (60) @(posedge clk);
            sw_in <= 22'h2a5c3e;
         end
      join
      chk("irq kept", 1'b1, int_n_oe);
      mswd_master_i.xfer(24'h123456, 24, st);
      chk("status kept", {2'b11, 22'h2a5c3e}, st);
      chk("irq cleared", 1'b0, int_n_oe);
      $display("interrupt keep test done");
   endtask
   // undriven select must not enable output
   task automatic t_float();
      mswd_master_i.float_sel(20, oe);
      chk("undriven select", 1'b0, oe);
      $display("float test done");
   endtask
   // sleep, scan window, wake by select, reread
   task automatic t_sleep();
      @(posedge clk);
      sleep_req <= 1'b1;
      wait_lvl(1, 1'b1);
      chk("asleep", 1'b1, asleep);
      wait_lvl(2, 1'b1);
      wait_lvl(2, 1'b0);
      chk("scan length", 1'b1, n >= 10 && n <= 30);
      @(posedge clk);
      sleep_req <= 1'b0;
      mswd_master_i.xfer(24'h000000, 24, st);
      chk("awake", 1'b0, asleep);
      mswd_master_i.xfer(24'h000000, 24, st);
      chk("reread status", {2'b01, 22'h2a5c3e}, st);
      $display("sleep test done");
   endtask
   // counts and verdict
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("reset so", 1'b0, so_oe);
      chk("reset irq", 1'b0, int_n_oe);
      chk("reset cmd", 24'h0, cmd_word);
      t_frame();
      t_short();
      t_keep();
      t_float();
      t_sleep();
      print_verdict();
   end
   // hang guard, well beyond the expected 16 us
   initial begin
      #200000;
      bad_count++;
      print_verdict();
   end
endmodule // mswd_core_bench
`default_nettype wire
